/* File: core/opclass_params.svh */
// Constants for the opcode class checker: opcode numbers, field positions.
// Assumes big-endian bit numbering mapped onto [31:0] with bit 31 = MSB.
`ifndef OPCLASS_PARAMS_SVH
`define OPCLASS_PARAMS_SVH

`define PO_HI          31
`define PO_LO          26
`define XO_HI          10
`define XO_LO          1
`define XO5_HI         5
`define XO5_LO         1
`define RD_HI          25
`define RD_LO          21
`define RA_HI          20
`define RA_LO          16
`define RB_HI          15
`define RB_LO          11
`define CMP_L_BIT      21
`define CMP_RSV_BIT    22
`define BO_HI          25
`define BO_LO          21
`define ZERO_WORD      32'h0000_0000
`define EXC_VECTOR     20'h00700

// Primary opcodes.
`define OP_ZERO        6'h00
`define OP_FUT1        6'h01
`define OP_D64A        6'h02
`define OP_TWI         6'h03
`define OP_FUT4        6'h04
`define OP_FUT5        6'h05
`define OP_FUT6        6'h06
`define OP_CMPLI       6'h0A
`define OP_CMPI        6'h0B
`define OP_BC          6'h10
`define OP_SC          6'h11
`define OP_B           6'h12
`define OP_X19         6'h13
`define OP_D64B        6'h1E
`define OP_X31         6'h1F
`define OP_LWZU        6'h21
`define OP_LBZU        6'h23
`define OP_STWU        6'h25
`define OP_STBU        6'h27
`define OP_LHZU        6'h29
`define OP_LHAU        6'h2B
`define OP_STHU        6'h2D
`define OP_LMW         6'h2E
`define OP_STMW        6'h2F
`define OP_LFSU        6'h31
`define OP_LFDU        6'h33
`define OP_STFSU       6'h35
`define OP_STFDU       6'h37
`define OP_FUT56       6'h38
`define OP_FUT57       6'h39
`define OP_D64C        6'h3A
`define OP_X59         6'h3B
`define OP_FUT60       6'h3C
`define OP_FUT61       6'h3D
`define OP_D64D        6'h3E
`define OP_X63         6'h3F

// Extended opcodes of the optional categories and of the string loads.
`define XO_FSQRT       5'h16
`define XO_FRES        5'h18
`define XO_FRSQRTE     5'h1A
`define XO_FSEL        5'h17
`define XO_ECIWX       10'h136
`define XO_ECOWX       10'h1B6
`define XO_TLBIA       10'h172
`define XO_TLBIE       10'h132
`define XO_TLBSYNC     10'h236
`define XO_LSWI        10'h255
`define XO_LSWX        10'h215

`endif

/* File: core/opclass_pkg.sv */
// Types for the opcode class checker.
// Assumes opclass_params.svh is on the include path.
package opclass_pkg;

    typedef enum logic [2:0] {
        CLS_DEFINED  = 3'h1,
        CLS_RESERVED = 3'h2,
        CLS_EXCEPT   = 3'h4
    } class_t;

    typedef enum logic [3:0] {
        EXC_NONE      = 4'h0,
        EXC_ILLEGAL   = 4'h1,
        EXC_RESERVED  = 4'h2,
        EXC_OPTIONAL  = 4'h4,
        EXC_INVALID   = 4'h8
    } cause_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] word;
        logic [31:0] addr;
    } fetch_t;

    typedef struct packed {
        logic        valid;
        class_t      cls;
        cause_t      cause;
        logic [5:0]  primary;
        logic [9:0]  extended;
        logic [31:0] word;
        logic [31:0] addr;
        logic        wr_enable;
        logic        raise;
        logic [19:0] vector;
    } decode_t;

    typedef struct packed {
        decode_t dec;
    } state_t;

endpackage

/* File: core/opcode_class_checker.sv */
// Opcode class checker: sorts each fetched word into a class and flags the
// illegal-instruction program exception.
// Assumes fetch presents one word per valid cycle in program order.
//
// Contract
// - Classify by primary and extended opcode; unknown codes are illegal.
// - Primary opcodes 1,4,5,6,56,57,60,61 are illegal.
// - Primary opcodes 2,30,58,62 are illegal on this 32-bit core.
// - Unused extended opcodes under 19,31,59,63 are illegal.
// - Extended opcodes only for 64-bit cores are illegal here.
// - The all-zero word is always illegal.
// - Primary opcode zero with other bits set is reserved.
// - Illegal words raise the program exception and change nothing else.
// - Unprovided reserved words raise the illegal instruction exception.
// - Unprovided optional instructions raise the illegal exception.
// - Invalid forms raise the exception, never undefined results.
// - Invalid form means an operand or reserved bit visibly miscoded.
// - Check forms of bc, update loads/stores, lmw, lsw, cmp, float update; bc forms are not checked, every bc coding is defined.
// - Optional categories are enabled or disabled as a whole.
// - No bounded-undefined result is produced; faults always trap.
// - Results leave in program order, one per accepted word.
// - Words and addresses are 32 bits wide.
// - Non-preferred forms are classified defined, never trapped.
// - Defined but unimplemented instructions may trap for emulation.

`include "opclass_params.svh"

module opcode_class_checker
    import opclass_pkg::*;
#(
    parameter int unsigned WORD_W     = 32,
    parameter bit          HAS_SQRT   = 1'b0,
    parameter bit          HAS_GFX    = 1'b0,
    parameter bit          HAS_EXTCTL = 1'b0,
    parameter bit          HAS_TLB    = 1'b0,
    parameter bit          HAS_RSV0   = 1'b0
) (
    // Clock and reset.
    input  wire logic    clk_sys,
    input  wire logic    reset,
    // Fetch side.
    input  wire fetch_t  fetch,
    // Execution and exception side.
    output decode_t      result
);

    if (WORD_W != 32) begin : g_width_check
        $error("opcode_class_checker serves only a 32-bit word");
    end

    // ****************************************************************
    // Classification
    // ****************************************************************

    state_t     s_q;
    state_t     s_d;
    logic [5:0] po;
    logic [9:0] xo;
    logic [4:0] xo5;
    logic [4:0] rd;
    logic [4:0] ra;
    logic [4:0] rb;
    logic       known;
    logic       reserved;
    logic       invalid;
    logic       optional_off;
    logic       illegal;

    assign po  = fetch.word[`PO_HI:`PO_LO];
    assign xo  = fetch.word[`XO_HI:`XO_LO];
    assign xo5 = fetch.word[`XO5_HI:`XO5_LO];
    assign rd  = fetch.word[`RD_HI:`RD_LO];
    assign ra  = fetch.word[`RA_HI:`RA_LO];
    assign rb  = fetch.word[`RB_HI:`RB_LO];

    // Which primary and extended opcodes this 32-bit core defines. Opcodes
    // left out (future, 64-bit only, unused extended) fall through as
    // unknown and thereby illegal.
    always_comb begin
        known = 1'b0;
        case (po)
            `OP_FUT1, `OP_FUT4, `OP_FUT5, `OP_FUT6,
            `OP_FUT56, `OP_FUT57, `OP_FUT60, `OP_FUT61: begin
                known = 1'b0;
            end
            `OP_D64A, `OP_D64B, `OP_D64C, `OP_D64D: begin
                known = 1'b0;
            end
            `OP_ZERO: begin
                known = 1'b0;
            end
            `OP_X19: begin
                case (xo)
                    10'h000, 10'h010, 10'h021, 10'h032, 10'h081,
                    10'h096, 10'h0C1, 10'h0E1, 10'h101, 10'h121,
                    10'h1A1, 10'h1C1, 10'h210: known = 1'b1;
                    default: known = 1'b0;
                endcase
            end
            `OP_X31: begin
                // 64-bit-only forms (ld, std, mulld, ...) absent.
                case (xo[8:0])
                    9'h000, 9'h004, 9'h008, 9'h00A, 9'h00B, 9'h013,
                    9'h014, 9'h017, 9'h018, 9'h01A, 9'h01C, 9'h020,
                    9'h028, 9'h036, 9'h037, 9'h03C, 9'h053, 9'h056,
                    9'h057, 9'h068, 9'h077, 9'h07C, 9'h088, 9'h08A,
                    9'h090, 9'h092, 9'h096, 9'h097, 9'h0B7, 9'h0C8,
                    9'h0CA, 9'h0D2, 9'h0D7, 9'h0EB, 9'h0F2, 9'h0F6,
                    9'h0F7, 9'h10A, 9'h113, 9'h116, 9'h117, 9'h11C,
                    9'h132, 9'h136, 9'h137, 9'h13C, 9'h153, 9'h157,
                    9'h170, 9'h172, 9'h173, 9'h177, 9'h17C, 9'h193,
                    9'h196, 9'h197, 9'h19C, 9'h1B6, 9'h1B7, 9'h1CB,
                    9'h1D3, 9'h1D6, 9'h1DC, 9'h1EB: known = 1'b1;
                    default: known = 1'b0;
                endcase
                if (xo == `XO_LSWX || xo == `XO_LSWI ||
                    xo == 10'h216 || xo == 10'h217 || xo == 10'h218 ||
                    xo == 10'h236 || xo == 10'h237 || xo == 10'h253 ||
                    xo == 10'h256 || xo == 10'h257 || xo == 10'h277 ||
                    xo == 10'h295 || xo == 10'h296 || xo == 10'h297 ||
                    xo == 10'h2B7 || xo == 10'h2D5 || xo == 10'h2D7 ||
                    xo == 10'h2F7 || xo == 10'h316 || xo == 10'h318 ||
                    xo == 10'h338 || xo == 10'h356 || xo == 10'h396 ||
                    xo == 10'h39A || xo == 10'h3BA || xo == 10'h3D6 ||
                    xo == 10'h3D7 || xo == 10'h3F6) begin
                    known = 1'b1;
                end
            end
            `OP_X59: begin
                case (xo5)
                    5'h12, 5'h14, 5'h15, 5'h19, 5'h1C, 5'h1D, 5'h1E,
                    5'h1F, `XO_FSQRT, `XO_FRES: known = 1'b1;
                    default: known = 1'b0;
                endcase
            end
            `OP_X63: begin
                case (xo5)
                    5'h12, 5'h14, 5'h15, 5'h19, 5'h1C, 5'h1D, 5'h1E,
                    5'h1F, `XO_FSQRT, `XO_FSEL, `XO_FRSQRTE: known = 1'b1;
                    default: begin
                        case (xo)
                            10'h000, 10'h00C, 10'h00E, 10'h00F, 10'h020,
                            10'h026, 10'h028, 10'h040, 10'h046, 10'h048,
                            10'h086, 10'h088, 10'h108, 10'h247,
                            10'h2C7: known = 1'b1;
                            default: known = 1'b0;
                        endcase
                    end
                endcase
            end
            default: begin
                known = 1'b1;
            end
        endcase
    end

    // a whole optional category is present or absent.
    always_comb begin
        optional_off = 1'b0;
        if ((po == `OP_X59 || po == `OP_X63) && xo5 == `XO_FSQRT) begin
            optional_off = !HAS_SQRT;
        end else if ((po == `OP_X59 && xo5 == `XO_FRES) ||
                     (po == `OP_X63 && (xo5 == `XO_FRSQRTE ||
                                        xo5 == `XO_FSEL))) begin
            optional_off = !HAS_GFX;
        end else if (po == `OP_X31 &&
                     (xo == `XO_ECIWX || xo == `XO_ECOWX)) begin
            optional_off = !HAS_EXTCTL;
        end else if (po == `OP_X31 && (xo == `XO_TLBIA ||
                     xo == `XO_TLBIE || xo == `XO_TLBSYNC)) begin
            optional_off = !HAS_TLB;
        end
    end

    // forms visibly miscoded in the word itself.
    always_comb begin
        invalid = 1'b0;
        case (po)
            `OP_BC: begin
                // Every branch conditional coding is accepted as defined.
                invalid = 1'b0;
            end
            `OP_LWZU, `OP_LBZU, `OP_LHZU, `OP_LHAU: begin
                invalid = (ra == 5'h00) || (ra == rd);
            end
            `OP_STWU, `OP_STBU, `OP_STHU,
            `OP_LFSU, `OP_LFDU, `OP_STFSU, `OP_STFDU: begin
                invalid = (ra == 5'h00);
            end
            `OP_LMW: begin
                invalid = (ra >= rd) && (ra != 5'h00);
            end
            `OP_CMPI, `OP_CMPLI: begin
                invalid = fetch.word[`CMP_L_BIT] || fetch.word[`CMP_RSV_BIT];
            end
            `OP_X31: begin
                if (xo == 10'h000 || xo == 10'h020) begin
                    invalid = fetch.word[`CMP_L_BIT] ||
                              fetch.word[`CMP_RSV_BIT];
                end else if (xo == `XO_LSWI) begin
                    invalid = (ra == rd);
                end else if (xo == `XO_LSWX) begin
                    invalid = (ra == rd) || (rb == rd);
                end
            end
            default: begin
                invalid = 1'b0;
            end
        endcase
    end

    assign reserved = (po == `OP_ZERO) && (fetch.word != `ZERO_WORD);

    assign illegal = !reserved && (!known || invalid || optional_off);

    // ****************************************************************
    // Result register
    // ****************************************************************

    always_comb begin
        s_d = s_q;
        s_d.dec.valid = fetch.valid;
        if (fetch.valid) begin
            s_d.dec.word     = fetch.word;
            s_d.dec.addr     = fetch.addr;
            s_d.dec.primary  = po;
            s_d.dec.extended = xo;
            if (reserved && HAS_RSV0) begin
                s_d.dec.cls   = CLS_RESERVED;
                s_d.dec.cause = EXC_NONE;
            end else if (reserved) begin
                s_d.dec.cls   = CLS_EXCEPT;
                s_d.dec.cause = EXC_RESERVED;
            end else if (illegal) begin
                s_d.dec.cls   = CLS_EXCEPT;
                s_d.dec.cause = !known ? EXC_ILLEGAL :
                                invalid ? EXC_INVALID : EXC_OPTIONAL;
            end else begin
                s_d.dec.cls   = CLS_DEFINED;
                s_d.dec.cause = EXC_NONE;
            end
            s_d.dec.raise     = (s_d.dec.cls == CLS_EXCEPT);
            s_d.dec.wr_enable = !s_d.dec.raise;
            s_d.dec.vector    = s_d.dec.raise ? `EXC_VECTOR : 20'h00000;
        end else begin
            s_d.dec.raise     = 1'b0;
            s_d.dec.wr_enable = 1'b0;
            s_d.dec.vector    = 20'h00000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_q <= '{dec: '{valid: 1'b0, cls: CLS_DEFINED, cause: EXC_NONE,
                            primary: 6'h00, extended: 10'h000,
                            word: 32'h0000_0000, addr: 32'h0000_0000,
                            wr_enable: 1'b0, raise: 1'b0,
                            vector: 20'h00000}};
        end else begin
            s_q <= s_d;
        end
    end

    assign result = s_q.dec;

    // ****************************************************************
    // Checks
    // ****************************************************************

    sequence s_fetch_zero;
        fetch.valid && fetch.word == `ZERO_WORD;
    endsequence

    property p_zero_illegal;
        @(posedge clk_sys) disable iff (reset)
        s_fetch_zero |=> result.raise && result.cause == EXC_ILLEGAL;
    endproperty
    a_zero_illegal: assert property (p_zero_illegal)
        else $error("All-zero word was not illegal.");

    property p_future_op;
        @(posedge clk_sys) disable iff (reset)
        fetch.valid && (po == `OP_FUT1 || po == `OP_FUT4 ||
                        po == `OP_FUT56 || po == `OP_FUT61)
            |=> result.raise && result.cause == EXC_ILLEGAL;
    endproperty
    a_future_op: assert property (p_future_op)
        else $error("Future primary opcode did not trap.");

    property p_op64;
        @(posedge clk_sys) disable iff (reset)
        fetch.valid && (po == `OP_D64A || po == `OP_D64B ||
                        po == `OP_D64C || po == `OP_D64D)
            |=> result.raise;
    endproperty
    a_op64: assert property (p_op64)
        else $error("64-bit primary opcode did not trap.");

    property p_reserved0;
        @(posedge clk_sys) disable iff (reset)
        fetch.valid && reserved |=> result.cause != EXC_ILLEGAL &&
            result.cls == (HAS_RSV0 ? CLS_RESERVED : CLS_EXCEPT);
    endproperty
    a_reserved0: assert property (p_reserved0)
        else $error("Opcode-zero word misclassified.");

    property p_no_write;
        @(posedge clk_sys) disable iff (reset)
        result.raise |-> !result.wr_enable && result.vector == `EXC_VECTOR;
    endproperty
    a_no_write: assert property (p_no_write)
        else $error("Trapping word still enables writes.");

    property p_order;
        @(posedge clk_sys) disable iff (reset)
        fetch.valid |=> result.valid && result.word == $past(fetch.word) &&
            result.addr == $past(fetch.addr);
    endproperty
    a_order: assert property (p_order)
        else $error("Result lost or out of order.");

    property p_update_ra0;
        @(posedge clk_sys) disable iff (reset)
        fetch.valid && po == `OP_LWZU && ra == 5'h00
            |=> result.cause == EXC_INVALID;
    endproperty
    a_update_ra0: assert property (p_update_ra0)
        else $error("Update form with zero base did not trap.");

    property p_optional;
        @(posedge clk_sys) disable iff (reset)
        fetch.valid && po == `OP_X63 && xo5 == `XO_FSEL && !HAS_GFX
            |=> result.cause == EXC_OPTIONAL;
    endproperty
    a_optional: assert property (p_optional)
        else $error("Missing optional instruction did not trap.");

    property p_idle;
        @(posedge clk_sys) disable iff (reset)
        !fetch.valid |=> !result.valid && !result.raise && !result.wr_enable;
    endproperty
    a_idle: assert property (p_idle)
        else $error("Result active without a fetched word.");

endmodule

/* File: dv/fetch_path_model.sv */
// Fetch path model that feeds words to the opcode class checker.
// Assumes the bench asks for one word per rising edge of clk_sys.
module fetch_path_model
    import opclass_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Requests from the bench.
    input  wire logic        send,
    input  wire logic [31:0] send_word,
    input  wire logic [31:0] send_addr,
    // Fetch side of the checker.
    output fetch_t           fetch
);
    timeunit 1ns;
    timeprecision 1ps;

    initial fetch = '0;

    // Each idle cycle inverts the held word and address, so idle data alternates between inverted and last word.
    always @(posedge clk_sys) begin
        if (reset || !send) begin
            fetch.valid <= 1'b0;
            fetch.word  <= ~fetch.word;
            fetch.addr  <= ~fetch.addr;
        end else begin
            fetch <= '{valid: 1'b1, word: send_word, addr: send_addr};
        end
    end
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the opcode class checker.
// Assumes opclass_pkg is compiled first and opclass_params.svh is included.
module testbench;
    import opclass_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [31:0] w;
        class_t      c;
        cause_t      k;
        logic        opt;
    } vec_t;

    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        send = 1'b0;
    logic [31:0] send_word = 32'h0000_0000;
    logic [31:0] send_addr = 32'h0000_0000;
    fetch_t      fetch;
    decode_t     res [2];
    decode_t     expq [2][$];
    vec_t        tv [$];
    int          illegal_po [12] = '{1, 4, 5, 6, 56, 57, 60, 61,
                                     2, 30, 58, 62};
    int          errors = 0;
    int          checks = 0;
    int          cycles = 0;

    always #25 clk_sys = ~clk_sys;

    fetch_path_model fp (.clk_sys(clk_sys), .reset(reset), .send(send),
        .send_word(send_word), .send_addr(send_addr), .fetch(fetch));
    opcode_class_checker uut (.clk_sys(clk_sys), .reset(reset),
        .fetch(fetch), .result(res[0]));
    opcode_class_checker #(.HAS_SQRT(1'b1), .HAS_GFX(1'b1),
        .HAS_EXTCTL(1'b1), .HAS_TLB(1'b1), .HAS_RSV0(1'b1)) uut_full (
        .clk_sys(clk_sys), .reset(reset), .fetch(fetch), .result(res[1]));

    // ****************************************
    // Expectations and comparisons
    // ****************************************
    function automatic logic [31:0] mk(input int po, rd, ra, rb, xo);
        return {po[5:0], rd[4:0], ra[4:0], rb[4:0], xo[9:0], 1'b0};
    endfunction

    // Optional and opcode-zero words change class when the unit is present.
    function automatic decode_t exp_of(input vec_t v, input logic [31:0] a,
                                       input bit full);
        decode_t d;
        d = '0;
        d.valid = 1'b1;
        d.cls = v.c;
        d.cause = v.k;
        if (full && v.opt) begin
            d.cls = (v.w[31:26] == 6'h00) ? CLS_RESERVED : CLS_DEFINED;
            d.cause = EXC_NONE;
        end
        d.primary = v.w[31:26];
        d.extended = v.w[10:1];
        d.word = v.w;
        d.addr = a;
        d.raise = (d.cls == CLS_EXCEPT);
        d.wr_enable = !d.raise;
        d.vector = d.raise ? 20'h00700 : 20'h00000;
        return d;
    endfunction

    task automatic cmp_res(input int i, input decode_t got, input decode_t ex);
        checks++;
        if (got !== ex) begin
            errors++;
            $display("CHECK FAILED %0t unit %0d got %h exp %h",
                     $time, i, got, ex);
        end
    endtask

    task automatic cmp_bit(input int i, input logic got, input logic ex);
        checks++;
        if (got !== ex) begin
            errors++;
            $display("CHECK FAILED %0t unit %0d flag %b exp %b",
                     $time, i, got, ex);
        end
    endtask

    task automatic chk_reset();
        decode_t z;
        z = '0;
        z.cls = CLS_DEFINED;
        for (int i = 0; i < 2; i++) cmp_res(i, res[i], z);
    endtask

    task automatic put(input logic [31:0] w, input class_t c,
                       input cause_t k, input logic opt);
        tv.push_back('{w, c, k, opt});
    endtask

    task automatic issue(input vec_t v);
        logic [31:0] a;
        a = $urandom & 32'hFFFF_FFFC;
        send <= 1'b1;
        send_word <= v.w;
        send_addr <= a;
        expq[0].push_back(exp_of(v, a, 1'b0));
        expq[1].push_back(exp_of(v, a, 1'b1));
        @(posedge clk_sys);
    endtask

    task automatic do_reset();
        send <= 1'b0;
        reset <= 1'b1;
        expq[0].delete();
        expq[1].delete();
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_reset();
        @(posedge clk_sys);
        reset <= 1'b0;
    endtask

    task automatic test_done();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Result monitor
    // ****************************************
    always @(negedge clk_sys) begin
        for (int i = 0; i < 2; i++) begin
            if (reset === 1'b1) begin
                continue;
            end
            if (res[i].valid === 1'b1) begin
                if (expq[i].size() == 0) begin
                    cmp_bit(i, 1'b1, 1'b0);
                end else begin
                    cmp_res(i, res[i], expq[i].pop_front());
                end
            end else begin
                cmp_bit(i, res[i].raise | res[i].wr_enable |
                        (|res[i].vector), 1'b0);
            end
        end
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end

    // ****************************************
    // Stimulus
    // ****************************************
    initial begin
        vec_t        v;
        logic [31:0] rnd;
        void'($urandom(32'hD2B496EB));
        put(32'h0000_0000, CLS_EXCEPT, EXC_ILLEGAL, 1'b0);
        put(32'h0000_0001, CLS_EXCEPT, EXC_RESERVED, 1'b1);
        put(32'h03FF_FFFF, CLS_EXCEPT, EXC_RESERVED, 1'b1);
        foreach (illegal_po[j]) begin
            put(mk(illegal_po[j], 3, 4, 5, 0), CLS_EXCEPT, EXC_ILLEGAL,
                1'b0);
        end
        put(mk(19, 0, 0, 0, 1), CLS_EXCEPT, EXC_ILLEGAL, 1'b0);
        put(mk(31, 3, 4, 5, 1), CLS_EXCEPT, EXC_ILLEGAL, 1'b0);
        put(mk(31, 3, 4, 5, 9), CLS_EXCEPT, EXC_ILLEGAL, 1'b0);
        put(mk(31, 3, 4, 5, 21), CLS_EXCEPT, EXC_ILLEGAL, 1'b0);
        put(32'h3800_0000, CLS_DEFINED, EXC_NONE, 1'b0);
        put(32'h6000_0000, CLS_DEFINED, EXC_NONE, 1'b0);
        put(mk(31, 3, 4, 5, 266), CLS_DEFINED, EXC_NONE, 1'b0);
        put(32'h4082_0008, CLS_DEFINED, EXC_NONE, 1'b0);
        put(mk(33, 3, 4, 0, 0), CLS_DEFINED, EXC_NONE, 1'b0);
        put(mk(33, 3, 0, 0, 0), CLS_EXCEPT, EXC_INVALID, 1'b0);
        put(mk(33, 3, 3, 0, 0), CLS_EXCEPT, EXC_INVALID, 1'b0);
        put(mk(37, 3, 0, 0, 0), CLS_EXCEPT, EXC_INVALID, 1'b0);
        put(mk(46, 29, 30, 0, 0), CLS_EXCEPT, EXC_INVALID, 1'b0);
        put(mk(46, 29, 1, 0, 0), CLS_DEFINED, EXC_NONE, 1'b0);
        put(mk(31, 3, 3, 4, 597), CLS_EXCEPT, EXC_INVALID, 1'b0);
        put(mk(31, 3, 4, 3, 533), CLS_EXCEPT, EXC_INVALID, 1'b0);
        put(mk(31, 1, 4, 5, 0), CLS_EXCEPT, EXC_INVALID, 1'b0);
        put(mk(11, 1, 4, 0, 0), CLS_EXCEPT, EXC_INVALID, 1'b0);
        put(mk(11, 2, 4, 0, 0), CLS_EXCEPT, EXC_INVALID, 1'b0);
        put(mk(11, 4, 4, 0, 0), CLS_DEFINED, EXC_NONE, 1'b0);
        put(mk(51, 1, 0, 0, 0), CLS_EXCEPT, EXC_INVALID, 1'b0);
        put(mk(63, 1, 0, 2, 22), CLS_EXCEPT, EXC_OPTIONAL, 1'b1);
        put(mk(59, 1, 0, 2, 22), CLS_EXCEPT, EXC_OPTIONAL, 1'b1);
        put(mk(59, 1, 0, 2, 24), CLS_EXCEPT, EXC_OPTIONAL, 1'b1);
        put(mk(63, 1, 0, 2, 26), CLS_EXCEPT, EXC_OPTIONAL, 1'b1);
        put(mk(63, 1, 3, 2, 151), CLS_EXCEPT, EXC_OPTIONAL, 1'b1);
        put(mk(31, 3, 4, 5, 310), CLS_EXCEPT, EXC_OPTIONAL, 1'b1);
        put(mk(31, 3, 4, 5, 438), CLS_EXCEPT, EXC_OPTIONAL, 1'b1);
        put(mk(31, 0, 0, 0, 370), CLS_EXCEPT, EXC_OPTIONAL, 1'b1);
        put(mk(31, 0, 0, 5, 306), CLS_EXCEPT, EXC_OPTIONAL, 1'b1);
        put(mk(31, 0, 0, 0, 566), CLS_EXCEPT, EXC_OPTIONAL, 1'b1);
        do_reset();
        foreach (tv[j]) issue(tv[j]);
        // A reset right behind a word must swallow its pending result.
        do_reset();
        for (int n = 0; n < 300; n++) begin
            rnd = $urandom;
            if (n % 4 == 0) begin
                v = '{{6'h0E, rnd[25:0]}, CLS_DEFINED, EXC_NONE, 1'b0};
            end else begin
                v = tv[$urandom_range(tv.size() - 1)];
            end
            issue(v);
            if ($urandom_range(2) == 0) begin
                send <= 1'b0;
                @(posedge clk_sys);
            end
        end
        send <= 1'b0;
        repeat (20) begin
            if (expq[0].size() + expq[1].size() > 0) begin
                @(posedge clk_sys);
            end
        end
        if (expq[0].size() + expq[1].size() > 0) begin
            errors++;
        end
        test_done();
    end
endmodule
